// ===== rtl/fcf_pkg.sv
// Notes on behaviour
// - ignore bit set: single faults not reported, no single-fault interrupt
// - ignore bit clear: every single fault on an array read is reported
// - wait-state field in config bits 3..2 sets read wait-states
// - wait-state field resets to 00, the maximum count
// - code 00 enables maximum wait-states, code 11 disables them
// - reserved codes read back as written but time like 00
// - maximum wait-state count is one cycle per array read
// - wait-state write while command runs is dropped, field unchanged
// - force-double bit set: every array read sets the double-fault flag
// - force-double clear: double-fault flag set only on genuine faults
// - force bits are plain read-write, hardware never clears them
// - force-single set: every array read sets single flag unless ignore bit set, irq if enabled
// - force-single clear: single flag set only on real single faults
// - single-fault irq enable gates the single-fault interrupt
// - every assigned error config bit is readable and writable
// - status: done, access, protection flags writable; busy, completion read-only
// - writing one to command-complete launches only while the flag is set and no access or protection flag is set; stays low until done, access error or violation
package fcf_pkg;
    localparam int unsigned AW = 4;
    localparam int unsigned DW = 8;
    localparam logic [3:0] OFS_CFG = 4'h4;
    localparam logic [3:0] OFS_ERRCFG = 4'h5;
    localparam logic [3:0] OFS_STAT = 4'h6;
    localparam logic [3:0] OFS_ERRSTAT = 4'h7;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFS_IRQ_CLR = 4'h9;
    localparam logic [3:0] OFS_IRQ_EN = 4'ha;
    localparam int unsigned CFG_COMMAND_COMPLETE_IRQ_ENABLE = 7;
    localparam int unsigned CFG_ERSA = 5;
    localparam int unsigned CFG_IGN = 4;
    localparam int unsigned CFG_WS_LO = 2;
    localparam int unsigned CFG_FDF = 1;
    localparam int unsigned CFG_FSF = 0;
    localparam int unsigned ERRCFG_SFIE = 0;
    localparam int unsigned ST_CCF = 7;
    localparam int unsigned ST_ACC = 5;
    localparam int unsigned ST_PV = 4;
    localparam int unsigned ST_BUSY = 3;
    localparam int unsigned ST_MG_LO = 0;
    localparam int unsigned ES_SF = 0;
    localparam int unsigned ES_DF = 1;
    localparam int unsigned IRQ_SF = 0;
    localparam int unsigned IRQ_DF = 1;
    localparam int unsigned IRQ_DONE = 2;
    localparam int unsigned IRQ_ERR = 3;
    localparam int unsigned IRQ_N = 4;
    localparam logic [1:0] WS_RST = 2'h0;
    localparam logic [1:0] WS_MAX = 2'h0;
    localparam logic [1:0] WS_OFF = 2'h3;
    localparam logic CCF_RST = 1'h1;
    localparam logic FLAG_RST = 1'h0;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam int unsigned WS_MAX_CYC = 1;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fcf_bus_s;
    typedef struct packed {
        logic rd_req;
        logic rd;
        logic sgl;
        logic dbl;
        logic done;
        logic acc_err;
        logic viol;
        logic busy;
        logic [1:0] completion_status_field;
    } fcf_core_s;
    typedef enum logic [0:0] {
        FCF_RD_IDLE = 1'b0,
        FCF_RD_WAIT = 1'b1
    } fcf_rd_e;
endpackage

// ===== rtl/fcf_regs.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module fcf_regs
    import fcf_pkg::*;
#(
    parameter int unsigned WS_CYC = WS_MAX_CYC
)
(
    input wire logic core_clk, // bus clock
    input wire logic resetn, // async reset, low active
    input wire logic ce, // clock enable, freezes state when low
    input wire fcf_bus_s bus, // register port request
    input wire fcf_core_s core, // controller core events
    output logic [7:0] rdata, // read data, cycle after read strobe
    output logic cmd_start, // one-cycle command launch pulse
    output logic [1:0] rd_wait, // wait-states applied per array read
    output logic rd_ack, // array read may complete
    output logic irq, // combined event interrupt
    output logic sf_irq, // single-fault interrupt level
    output logic cc_irq // command-complete interrupt level
);
    // refuse a zero wait count and counts that the two-bit pacing counter cannot hold
    if (WS_CYC < 1 || WS_CYC > 3)
    begin : g_ws_check
        $error("WS_CYC must be 1..3");
    end

    localparam logic [1:0] WS_N = WS_CYC[1:0];

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    logic command_complete_irq_enable_q;
    logic ign_q;
    logic [1:0] ws_q;
    logic fdf_q;
    logic fsf_q;
    logic sfie_q;
    logic ccf_q;
    logic acc_q;
    logic pv_q;
    logic sf_q;
    logic df_q;
    logic [3:0] ists_q;
    logic [3:0] ien_q;
    logic [7:0] rdata_q;
    logic cmd_start_q;
    logic [1:0] rd_wait_q;
    logic rd_ack_q;
    logic irq_q;
    logic sf_irq_q;
    logic cc_irq_q;
    fcf_rd_e rd_st_q;
    logic [1:0] rd_cnt_q;

    logic wr_cfg;
    logic wr_errcfg;
    logic wr_stat;
    logic wr_errstat;
    logic wr_iclr;
    logic wr_ien;
    logic launch;
    logic rep_sf;
    logic rep_df;
    logic [3:0] evt;
    logic [7:0] rd_mux;

    assign wr_cfg = bus.wr && hit(bus.addr, OFS_CFG);
    assign wr_errcfg = bus.wr && hit(bus.addr, OFS_ERRCFG);
    assign wr_stat = bus.wr && hit(bus.addr, OFS_STAT);
    assign wr_errstat = bus.wr && hit(bus.addr, OFS_ERRSTAT);
    assign wr_iclr = bus.wr && hit(bus.addr, OFS_IRQ_CLR);
    assign wr_ien = bus.wr && hit(bus.addr, OFS_IRQ_EN);

    // a launch is refused while an error flag blocks new commands
    assign launch = wr_stat && bus.wdata[ST_CCF] && ccf_q && !acc_q && !pv_q;

    // forced faults pass through the same ignore gate as real ones
    assign rep_sf = core.rd && (core.sgl || fsf_q) && !ign_q;
    assign rep_df = core.rd && (core.dbl || fdf_q);

    assign evt[IRQ_SF] = rep_sf;
    assign evt[IRQ_DF] = rep_df;
    assign evt[IRQ_DONE] = core.done;
    assign evt[IRQ_ERR] = core.acc_err || core.viol;

    // configuration register
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            command_complete_irq_enable_q <= 1'b0;
            ign_q <= 1'b0;
            ws_q <= WS_RST;
            fdf_q <= 1'b0;
            fsf_q <= 1'b0;
        end
        else if (ce && wr_cfg)
        begin
            command_complete_irq_enable_q <= bus.wdata[CFG_COMMAND_COMPLETE_IRQ_ENABLE];
            ign_q <= bus.wdata[CFG_IGN];
            fdf_q <= bus.wdata[CFG_FDF];
            fsf_q <= bus.wdata[CFG_FSF];
            // a switch mid-command would retime a running array access
            if (ccf_q)
            begin
                ws_q <= bus.wdata[CFG_WS_LO +: 2];
            end
        end
    end

    // error configuration register
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sfie_q <= 1'b0;
        end
        else if (ce && wr_errcfg)
        begin
            sfie_q <= bus.wdata[ERRCFG_SFIE];
        end
    end

    // command complete flag
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ccf_q <= CCF_RST;
        end
        else if (ce)
        begin
            if (core.done || core.acc_err || core.viol)
            begin
                ccf_q <= 1'b1;
            end
            else if (launch)
            begin
                ccf_q <= 1'b0;
            end
        end
    end

    // access error and protection flags, write one to clear, set wins
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_q <= FLAG_RST;
            pv_q <= FLAG_RST;
        end
        else if (ce)
        begin
            acc_q <= core.acc_err || (acc_q && !(wr_stat && bus.wdata[ST_ACC]));
            pv_q <= core.viol || (pv_q && !(wr_stat && bus.wdata[ST_PV]));
        end
    end

    // launch pulse toward the command sequencer
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmd_start_q <= 1'b0;
        end
        else if (ce)
        begin
            cmd_start_q <= launch;
        end
    end

    // error status flags, write one to clear, set wins
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sf_q <= FLAG_RST;
            df_q <= FLAG_RST;
        end
        else if (ce)
        begin
            sf_q <= rep_sf || (sf_q && !(wr_errstat && bus.wdata[ES_SF]));
            df_q <= rep_df || (df_q && !(wr_errstat && bus.wdata[ES_DF]));
        end
    end

    // event interrupt status and enable
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ists_q <= IRQ_RST;
            ien_q <= IRQ_RST;
        end
        else if (ce)
        begin
            ists_q <= evt | (ists_q & ~(wr_iclr ? bus.wdata[IRQ_N-1:0] : 4'h0));
            if (wr_ien)
            begin
                ien_q <= bus.wdata[IRQ_N-1:0];
            end
        end
    end

    // interrupt outputs, one cycle behind the flags
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_q <= 1'b0;
            sf_irq_q <= 1'b0;
            cc_irq_q <= 1'b0;
        end
        else if (ce)
        begin
            irq_q <= |(ists_q & ien_q);
            sf_irq_q <= sf_q && sfie_q && !ign_q;
            cc_irq_q <= ccf_q && command_complete_irq_enable_q;
        end
    end

    // wait-state count; reserved codes fall back to the maximum
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_wait_q <= WS_N;
        end
        else if (ce)
        begin
            rd_wait_q <= (ws_q == WS_OFF) ? 2'h0 : WS_N;
        end
    end

    // read pacing: ack after the programmed wait-states
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_st_q <= FCF_RD_IDLE;
            rd_cnt_q <= 2'h0;
            rd_ack_q <= 1'b0;
        end
        else if (ce)
        begin
            rd_ack_q <= 1'b0;
            case (rd_st_q)
                FCF_RD_IDLE:
                begin
                    if (core.rd_req)
                    begin
                        if (rd_wait_q == 2'h0)
                        begin
                            rd_ack_q <= 1'b1;
                        end
                        else
                        begin
                            rd_cnt_q <= rd_wait_q;
                            rd_st_q <= FCF_RD_WAIT;
                        end
                    end
                end
                FCF_RD_WAIT:
                begin
                    if (rd_cnt_q == 2'h1)
                    begin
                        rd_ack_q <= 1'b1;
                        rd_st_q <= FCF_RD_IDLE;
                    end
                    rd_cnt_q <= rd_cnt_q - 2'h1;
                end
                default:
                begin
                    rd_st_q <= FCF_RD_IDLE;
                end
            endcase
        end
    end

    // read mux; unmapped and write-only offsets read zero
    always_comb
    begin
        rd_mux = 8'h00;
        case (bus.addr)
            OFS_CFG:
            begin
                rd_mux[CFG_COMMAND_COMPLETE_IRQ_ENABLE] = command_complete_irq_enable_q;
                rd_mux[CFG_IGN] = ign_q;
                rd_mux[CFG_WS_LO +: 2] = ws_q;
                rd_mux[CFG_FDF] = fdf_q;
                rd_mux[CFG_FSF] = fsf_q;
            end
            OFS_ERRCFG:
            begin
                rd_mux[ERRCFG_SFIE] = sfie_q;
            end
            OFS_STAT:
            begin
                rd_mux[ST_CCF] = ccf_q;
                rd_mux[ST_ACC] = acc_q;
                rd_mux[ST_PV] = pv_q;
                rd_mux[ST_BUSY] = core.busy;
                rd_mux[ST_MG_LO +: 2] = core.completion_status_field;
            end
            OFS_ERRSTAT:
            begin
                rd_mux[ES_SF] = sf_q;
                rd_mux[ES_DF] = df_q;
            end
            OFS_IRQ_STAT:
            begin
                rd_mux[IRQ_N-1:0] = ists_q;
            end
            OFS_IRQ_EN:
            begin
                rd_mux[IRQ_N-1:0] = ien_q;
            end
            default:
            begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // read data stands one cycle for each cycle the read strobe is high
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_q <= 8'h00;
        end
        else if (ce)
        begin
            rdata_q <= bus.rd ? rd_mux : 8'h00;
        end
    end

    assign rdata = rdata_q;
    assign cmd_start = cmd_start_q;
    assign rd_wait = rd_wait_q;
    assign rd_ack = rd_ack_q;
    assign irq = irq_q;
    assign sf_irq = sf_irq_q;
    assign cc_irq = cc_irq_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    a_ign_no_report: assert property ((ce && ign_q && !sf_q) |=> !sf_q)
        else $error("single fault reported while ignored");
    a_sf_reported: assert property ((ce && core.rd && core.sgl && !ign_q) |=> sf_q)
        else $error("single fault not reported");
    a_ws_reserved: assert property ((ce && ws_q != WS_OFF) |=> rd_wait_q == WS_N)
        else $error("reserved or max code not at maximum wait");
    a_ws_disabled: assert property ((ce && ws_q == WS_OFF) |=> rd_wait_q == 2'h0)
        else $error("disabled code still waits");
    a_ws_busy_hold: assert property ((ce && wr_cfg && !ccf_q) |=> $stable(ws_q))
        else $error("wait field changed during command");
    a_df_forced: assert property ((ce && core.rd && fdf_q) |=> df_q)
        else $error("forced double fault not flagged");
    a_df_genuine: assert property ((ce && !df_q && !(core.rd && (core.dbl || fdf_q)))
        |=> !df_q)
        else $error("double fault flag set without cause");
    a_force_kept: assert property ((ce && fsf_q && !wr_cfg) |=> fsf_q)
        else $error("force bit cleared by hardware");
    a_sf_forced: assert property ((ce && core.rd && fsf_q && !ign_q) |=> sf_q)
        else $error("forced single fault not flagged");
    a_sf_irq_on: assert property ((ce && sf_q && sfie_q && !ign_q) |=> sf_irq_q)
        else $error("single fault irq missing");
    a_sf_irq_off: assert property ((ce && !sfie_q) |=> !sf_irq_q)
        else $error("single fault irq while disabled");
    a_ccf_stays: assert property ((ce && !ccf_q && !core.done && !core.acc_err && !core.viol)
        |=> !ccf_q)
        else $error("command complete rose early");
    a_busy_ro: assert property ((ce && bus.rd && hit(bus.addr, OFS_STAT))
        |=> rdata_q[ST_BUSY] == $past(core.busy))
        else $error("busy readback wrong");
endmodule // fcf_regs

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import fcf_pkg::*;
    localparam int WS = 1;
    localparam logic [6:0] P_REQ = 7'h40;
    localparam logic [6:0] P_RD = 7'h20;
    localparam logic [6:0] P_SGL = 7'h10;
    localparam logic [6:0] P_DBL = 7'h08;
    localparam logic [6:0] P_DONE = 7'h04;
    localparam logic [6:0] P_ACC = 7'h02;
    localparam logic [6:0] P_VIOL = 7'h01;
    logic core_clk;
    logic resetn;
    logic ce;
    fcf_bus_s bus_q;
    fcf_core_s core_q;
    logic [7:0] rdata;
    logic cmd_start;
    logic [1:0] rd_wait;
    logic rd_ack;
    logic irq;
    logic sf_irq;
    logic cc_irq;
    int n_fail;
    int compares;
    int cycles;
    int n;
    logic [7:0] v;
    logic s;
    logic d;
    logic e;

    fcf_regs #(.WS_CYC(WS)) fcf_regs_inst (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .bus(bus_q),
        .core(core_q),
        .rdata(rdata),
        .cmd_start(cmd_start),
        .rd_wait(rd_wait),
        .rd_ack(rd_ack),
        .irq(irq),
        .sf_irq(sf_irq),
        .cc_irq(cc_irq)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [1:0] exp_wait(input logic [1:0] code);
        // reserved codes time like the maximum setting
        return (code == WS_OFF) ? 2'h0 : 2'(WS);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] dt);
        @(posedge core_clk);
        bus_q <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_q.wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_q.rd <= 1'b0;
        #1 check(rdata, exp);
    endtask

    // one-cycle event pulses; busy and completion levels are left alone
    task automatic pulse(input logic [6:0] f);
        @(posedge core_clk);
        core_q <= {f, core_q[2:0]};
        @(posedge core_clk);
        core_q <= {7'h00, core_q[2:0]};
    endtask

    always @(posedge core_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_fail = n_fail + 1;
            results();
        end
    end

    initial
    begin
        n_fail = 0;
        compares = 0;
        cycles = 0;
        resetn = 1'b0;
        ce = 1'b1;
        bus_q = '0;
        core_q = '0;
        void'($urandom(20795));
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        #1 check({6'h00, rd_wait}, 8'h01);
        rdchk(OFS_CFG, 8'h00);
        rdchk(OFS_STAT, 8'h80);
        rdchk(OFS_ERRSTAT, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom);
            v[3:2] = 2'(i);
            wr(OFS_CFG, v);
            rdchk(OFS_CFG, v & 8'h9f);
            check({6'h00, rd_wait}, {6'h00, exp_wait(2'(i))});
            pulse(P_REQ);
            n = 1;
            #1;
            while (rd_ack !== 1'b1 && n < 6)
            begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
            check(8'(n), 8'(1 + exp_wait(2'(i))));
        end
        v = 8'($urandom);
        wr(OFS_ERRCFG, v);
        rdchk(OFS_ERRCFG, v & 8'h01);
        // a write while the clock enable is low must leave no trace
        @(posedge core_clk);
        ce <= 1'b0;
        wr(OFS_ERRCFG, ~v);
        ce <= 1'b1;
        rdchk(OFS_ERRCFG, v & 8'h01);
        wr(4'h0, 8'hff);
        rdchk(4'h0, 8'h00);
        rdchk(4'hf, 8'h00);
        // forced faults with interrupts open
        wr(OFS_CFG, 8'h03);
        wr(OFS_ERRCFG, 8'h01);
        wr(OFS_IRQ_EN, 8'h03);
        pulse(P_RD);
        rdchk(OFS_ERRSTAT, 8'h03);
        check({7'h00, sf_irq}, 8'h01);
        check({7'h00, irq}, 8'h01);
        rdchk(OFS_IRQ_STAT, 8'h03);
        rdchk(OFS_CFG, 8'h03);
        wr(OFS_ERRSTAT, 8'h01);
        rdchk(OFS_ERRSTAT, 8'h02);
        check({7'h00, sf_irq}, 8'h00);
        wr(OFS_IRQ_CLR, 8'h0f);
        rdchk(OFS_IRQ_STAT, 8'h00);
        check({7'h00, irq}, 8'h00);
        wr(OFS_IRQ_EN, 8'h00);
        wr(OFS_ERRSTAT, 8'h03);
        // ignore bit also hides forced single faults
        wr(OFS_CFG, 8'h11);
        pulse(P_RD | P_SGL);
        rdchk(OFS_ERRSTAT, 8'h00);
        check({7'h00, sf_irq}, 8'h00);
        wr(OFS_CFG, 8'h00);
        pulse(P_SGL | P_DBL);
        rdchk(OFS_ERRSTAT, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            s = 1'($urandom);
            d = 1'($urandom);
            e = 1'($urandom);
            wr(OFS_ERRCFG, {7'h00, e});
            pulse(P_RD | (s ? P_SGL : 7'h00) | (d ? P_DBL : 7'h00));
            rdchk(OFS_ERRSTAT, {6'h00, d, s});
            check({7'h00, sf_irq}, {7'h00, s & e});
            check({7'h00, irq}, 8'h00);
            wr(OFS_ERRSTAT, 8'h03);
        end
        // command launch and wait field lock
        wr(OFS_IRQ_CLR, 8'h0f);
        wr(OFS_CFG, 8'h80);
        wr(OFS_STAT, 8'h80);
        #1 check({7'h00, cmd_start}, 8'h01);
        @(posedge core_clk);
        core_q[2:0] <= 3'b110;
        rdchk(OFS_STAT, 8'h0a);
        check({7'h00, cc_irq}, 8'h00);
        wr(OFS_STAT, 8'h0f);
        rdchk(OFS_STAT, 8'h0a);
        wr(OFS_CFG, 8'h8c);
        rdchk(OFS_CFG, 8'h80);
        check({6'h00, rd_wait}, 8'h01);
        wr(OFS_STAT, 8'h80);
        #1 check({7'h00, cmd_start}, 8'h00);
        @(posedge core_clk);
        core_q[2:0] <= 3'b000;
        pulse(P_DONE);
        rdchk(OFS_STAT, 8'h80);
        check({7'h00, cc_irq}, 8'h01);
        pulse(P_ACC);
        rdchk(OFS_STAT, 8'ha0);
        wr(OFS_STAT, 8'h80);
        #1 check({7'h00, cmd_start}, 8'h00);
        wr(OFS_STAT, 8'h20);
        rdchk(OFS_STAT, 8'h80);
        pulse(P_VIOL);
        rdchk(OFS_STAT, 8'h90);
        wr(OFS_STAT, 8'h10);
        rdchk(OFS_STAT, 8'h80);
        wr(OFS_CFG, 8'h8c);
        rdchk(OFS_CFG, 8'h8c);
        check({6'h00, rd_wait}, 8'h00);
        // done, access and protection events since the clear, nothing else
        rdchk(OFS_IRQ_STAT, 8'h0c);
        wr(OFS_IRQ_EN, 8'h04);
        @(posedge core_clk);
        #1 check({7'h00, irq}, 8'h01);
        results();
    end
endmodule // testbench
